// file: design/vfd_shutdown_cursor_font_regs.sv
module vfd_shutdown_cursor_font_regs #(
  parameter int INDICATOR_COUNT = 4,
  parameter int MUX_PERIOD_CYCLES = vfd_pkg::MUX_PERIOD_CYCLES,
  parameter int MUX_HALF_CYCLES = vfd_pkg::MUX_HALF_CYCLES,
  parameter int BLINK_SLOW_CYCLES = vfd_pkg::BLINK_SLOW_CYCLES,
  parameter int BLINK_FAST_CYCLES = vfd_pkg::BLINK_FAST_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic reset_n,

  // Serial command pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,

  // Output configuration from elsewhere
  input wire logic pump_is_clock,
  input wire logic phase_a_is_filament,
  input wire logic phase_b_is_filament,

  // Glyph lookup from the scan
  input wire logic [4:0] glyph_char,
  input wire logic digit_wide,
  output logic [13:0] glyph_segments,

  // Tube and supply outputs
  output logic tube_driver_disable_out,
  output logic multiplex_clock,
  output logic pump_out,
  output logic filament_drive_out_a,
  output logic filament_drive_out_b,

  // Configuration state
  output logic blink_phase,
  output logic display_mode,
  output logic font_select,
  output logic config_locked,

  // Cursor
  output logic cursor_row,
  output logic [5:0] cursor_digit,
  output logic cursor_lit,

  // Indicators, one bit per indicator byte
  output logic [INDICATOR_COUNT-1:0] indicator_first,
  output logic [INDICATOR_COUNT-1:0] indicator_second,
  output logic [INDICATOR_COUNT-1:0] indicator_third,
  output logic [INDICATOR_COUNT-1:0] indicator_fourth
);

  localparam int IDX_W = (INDICATOR_COUNT > 1) ? $clog2(INDICATOR_COUNT) : 1;

  // Received words
  logic word_valid;
  logic [15:0] word;
  logic [7:0] read_byte;

  // Register state
  logic [6:0] global_configuration;
  logic [7:0] cursor_select;
  logic [7:0] test_control;
  logic [INDICATOR_COUNT-1:0][7:0] indicator_blink_byte;

  // Glyph storage and pointer
  logic [vfd_pkg::GLYPH_ENTRIES-1:0][6:0] user_glyph_slot;
  logic [5:0] glyph_pointer;
  logic glyph_stuck;

  // Power sequencing
  vfd_pkg::power_state_t state;
  vfd_pkg::power_state_t next_state;
  logic period_end;
  logic filament_phase;

  // Serial front end; pins are synchronised inside
  spi_word_rx u_rx (
    .clk(clk),
    .reset_n(reset_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout(dout),
    .reply(read_byte),
    .word_valid(word_valid),
    .word(word)
  );

  // Word split into command and data
  wire [7:0] cmd = word[15:8];
  wire [7:0] data = word[7:0];
  wire is_read = cmd[vfd_pkg::READ_FLAG];
  wire [7:0] reg_addr = {1'b0, cmd[6:0]};

  // Strobes exist only once the whole word is in
  wire wr = word_valid & ~is_read;
  wire rd = word_valid & is_read;

  // Address decode, with no shutdown gating
  wire hit_config = reg_addr == vfd_pkg::CMD_CONFIG;
  wire hit_glyph = reg_addr == vfd_pkg::CMD_GLYPH;
  wire hit_test = reg_addr == vfd_pkg::CMD_TEST;
  wire hit_cursor = reg_addr == vfd_pkg::CMD_CURSOR;
  wire [7:0] ind_offset = reg_addr - vfd_pkg::CMD_INDICATOR_BASE;
  wire hit_ind = (reg_addr >= vfd_pkg::CMD_INDICATOR_BASE) &&
                 (ind_offset < 8'(INDICATOR_COUNT));
  wire [IDX_W-1:0] ind_index = ind_offset[IDX_W-1:0];

  // Config side effects are one-shot on the write
  wire config_wr = wr & hit_config;
  wire global_clear = config_wr & data[vfd_pkg::CFG_CLEAR];
  wire blink_sync = config_wr & data[vfd_pkg::CFG_SYNC];

  // Glyph port: data below 0x80, pointer at or above
  wire ptr_wr = wr & hit_glyph & data[vfd_pkg::POINTER_FLAG];
  wire glyph_wr = wr & hit_glyph & ~data[vfd_pkg::POINTER_FLAG];
  wire glyph_rd = rd & hit_glyph;
  wire ptr_in_range = data <= vfd_pkg::POINTER_LAST;
  wire glyph_access = (glyph_wr | glyph_rd) & ~glyph_stuck;
  wire ptr_at_last = glyph_pointer == vfd_pkg::GLYPH_LAST;
  wire [7:0] ptr_offset = data - vfd_pkg::POINTER_BASE;

  // Load in range, zero out of range
  wire [5:0] ptr_loaded = ptr_in_range ? ptr_offset[5:0] : 6'h00;
  wire [5:0] ptr_bumped = ptr_at_last ? glyph_pointer : glyph_pointer + 6'h01;
  wire [5:0] next_glyph_pointer = ptr_wr ? ptr_loaded :
                                  glyph_access ? ptr_bumped : glyph_pointer;

  // Shutdown request; test mode always keeps it running
  wire test_mode = test_control[0];
  wire want_shutdown = ~global_configuration[vfd_pkg::CFG_SHUTDOWN] & ~test_mode;

  // Stopping or halted: outputs held low; flush drives them again
  wire hold_low = (state == vfd_pkg::ST_STOPPING) || (state == vfd_pkg::ST_HALTED);
  wire osc_run = state != vfd_pkg::ST_HALTED;

  // A fresh period starts when leaving shutdown
  wire enter_flush = (next_state == vfd_pkg::ST_FLUSH) && (state != vfd_pkg::ST_FLUSH);
  wire timer_restart = enter_flush | blink_sync;

  // Live phase goes into the config readback
  wire [7:0] config_view = {blink_phase, global_configuration};
  wire [7:0] glyph_view = glyph_stuck ? 8'h00 : {1'b0, user_glyph_slot[glyph_pointer]};

  // Read selection; unmapped reads give zero
  wire [7:0] read_value = hit_config ? config_view :
                          hit_glyph ? glyph_view :
                          hit_cursor ? cursor_select :
                          hit_test ? test_control :
                          hit_ind ? indicator_blink_byte[ind_index] : 8'h00;

  // Glyph lookup for the scan
  wire glyph_char_ok = glyph_char < 5'(vfd_pkg::GLYPH_CHARS);
  wire [5:0] glyph_entry = {glyph_char, 1'b0};
  wire [6:0] glyph_byte0 = user_glyph_slot[glyph_entry];
  wire [6:0] glyph_byte1 = user_glyph_slot[glyph_entry + 6'h01];

  // Byte 1 only means something on wide digits
  wire [13:0] next_glyph_segments = !glyph_char_ok ? 14'h0000 :
                                    {digit_wide ? glyph_byte1 : 7'h00, glyph_byte0};

  // Cursor decode
  wire cursor_hidden = cursor_select[vfd_pkg::CURSOR_ROW] & cursor_select[vfd_pkg::CURSOR_HIDE];
  wire cursor_blinks = cursor_select[vfd_pkg::CURSOR_BLINK];
  wire next_cursor_lit = ~cursor_hidden & (~cursor_blinks | ~blink_phase);

  // Multiplex and blink timing
  mux_blink_timer #(
    .MUX_CYCLES(MUX_PERIOD_CYCLES),
    .OSC_HALF(MUX_HALF_CYCLES),
    .SLOW_CYCLES(BLINK_SLOW_CYCLES),
    .FAST_CYCLES(BLINK_FAST_CYCLES)
  ) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .run(osc_run),
    .restart(timer_restart),
    .blink_clear(blink_sync),
    .fast(global_configuration[vfd_pkg::CFG_RATE]),
    .period_end(period_end),
    .osc_out(multiplex_clock),
    .blink_phase(blink_phase)
  );

  // Indicator code to lit, for the current blink half
  function automatic logic code_lit(input logic [1:0] code, input logic phase);
    code_lit = (code == vfd_pkg::IND_ON) ||
               (code == vfd_pkg::IND_FIRST && !phase) ||
               (code == vfd_pkg::IND_SECOND && phase);
  endfunction

  // Shutdown sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      vfd_pkg::ST_RUN: begin
        if (want_shutdown) begin
          next_state = vfd_pkg::ST_STOPPING;
        end
      end
      vfd_pkg::ST_STOPPING: begin
        if (!want_shutdown) begin
          next_state = vfd_pkg::ST_FLUSH;
        end else if (period_end) begin
          next_state = vfd_pkg::ST_HALTED;
        end
      end
      vfd_pkg::ST_HALTED: begin
        if (!want_shutdown) begin
          next_state = vfd_pkg::ST_FLUSH;
        end
      end
      vfd_pkg::ST_FLUSH: begin
        if (want_shutdown) begin
          next_state = vfd_pkg::ST_STOPPING;
        end else if (period_end) begin
          next_state = vfd_pkg::ST_RUN;
        end
      end
    endcase
  end

  // State register; power-up is shutdown
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= vfd_pkg::ST_HALTED;
    end else begin
      state <= next_state;
    end
  end

  // Tube blanked in every state but running
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tube_driver_disable_out <= 1'b1;
    end else begin
      tube_driver_disable_out <= next_state != vfd_pkg::ST_RUN;
    end
  end

  // Filament full-bridge phase follows the multiplex period
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      filament_phase <= 1'b0;
    end else if (period_end) begin
      filament_phase <= ~filament_phase;
    end
  end

  // Supply outputs; only the configured roles are driven here
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pump_out <= 1'b0;
      filament_drive_out_a <= 1'b0;
      filament_drive_out_b <= 1'b0;
    end else begin
      pump_out <= pump_is_clock & ~hold_low & multiplex_clock;
      filament_drive_out_a <= phase_a_is_filament & ~hold_low & filament_phase;
      filament_drive_out_b <= phase_b_is_filament & ~hold_low & ~filament_phase;
    end
  end

  // Configuration; the phase bit is read-only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      global_configuration <= vfd_pkg::CONFIG_RESET;
    end else if (config_wr) begin
      global_configuration <= data[6:0];
    end
  end

  // Cursor and test registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cursor_select <= vfd_pkg::CURSOR_RESET;
      test_control <= vfd_pkg::TEST_RESET;
    end else begin
      if (wr && hit_cursor) begin
        cursor_select <= data;
      end
      if (wr && hit_test) begin
        test_control <= data;
      end
    end
  end

  // Glyph pointer and end-of-range latch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      glyph_pointer <= 6'h00;
      glyph_stuck <= 1'b0;
    end else begin
      glyph_pointer <= next_glyph_pointer;
      if (ptr_wr) begin
        glyph_stuck <= 1'b0;
      end else if (glyph_access && ptr_at_last) begin
        glyph_stuck <= 1'b1;
      end
    end
  end

  // Reply for the next frame
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      read_byte <= 8'h00;
    end else if (rd) begin
      read_byte <= read_value;
    end
  end

  // Glyph slots; odd slots are byte 1 and power up blank
  for (genvar i = 0; i < vfd_pkg::GLYPH_ENTRIES; i++) begin : g_glyph
    localparam logic [6:0] SLOT_RESET = (i % 2 == 0) ? vfd_pkg::GLYPH_DEFAULTS[i / 2] : 7'h00;
    wire slot_wr = glyph_wr & ~glyph_stuck & (glyph_pointer == 6'(i));
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        user_glyph_slot[i] <= SLOT_RESET;
      end else if (slot_wr) begin
        user_glyph_slot[i] <= data[6:0];
      end
    end
  end

  // Indicator bytes and their lit outputs
  for (genvar i = 0; i < INDICATOR_COUNT; i++) begin : g_ind
    wire byte_wr = wr & hit_ind & (ind_index == IDX_W'(i));
    wire [7:0] ind = indicator_blink_byte[i];
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        indicator_blink_byte[i] <= vfd_pkg::INDICATOR_RESET;
      end else if (global_clear) begin
        indicator_blink_byte[i] <= vfd_pkg::INDICATOR_RESET;
      end else if (byte_wr) begin
        indicator_blink_byte[i] <= data;
      end
    end

    // Data survives shutdown; only the tube is blanked
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        indicator_first[i] <= 1'b0;
        indicator_second[i] <= 1'b0;
        indicator_third[i] <= 1'b0;
        indicator_fourth[i] <= 1'b0;
      end else begin
        indicator_first[i] <= code_lit(ind[1:0], blink_phase);
        indicator_second[i] <= code_lit(ind[3:2], blink_phase);
        indicator_third[i] <= code_lit(ind[5:4], blink_phase);
        indicator_fourth[i] <= code_lit(ind[7:6], blink_phase);
      end
    end
  end

  // Registered views of state for the scan logic
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      glyph_segments <= 14'h0000;
      cursor_row <= 1'b0;
      cursor_digit <= 6'h00;
      cursor_lit <= 1'b0;
      display_mode <= 1'b0;
      font_select <= 1'b0;
      config_locked <= 1'b0;
    end else begin
      glyph_segments <= next_glyph_segments;
      cursor_row <= cursor_select[vfd_pkg::CURSOR_ROW];
      cursor_digit <= cursor_select[5:0];
      cursor_lit <= next_cursor_lit;
      display_mode <= global_configuration[vfd_pkg::CFG_MODE];
      font_select <= global_configuration[vfd_pkg::CFG_FONT];
      config_locked <= global_configuration[vfd_pkg::CFG_LOCK];
    end
  end

endmodule

// file: design/vfd_pkg.sv
package vfd_pkg;

  // Clock rate and timing figures
  localparam int CLK_KHZ = 50000;
  localparam int MUX_PERIOD_US = 100;
  localparam int MUX_PERIOD_CYCLES = (MUX_PERIOD_US * CLK_KHZ) / 1000;
  localparam int MUX_CLOCK_KHZ = 4000;
  localparam int MUX_HALF_CYCLES = CLK_KHZ / (2 * MUX_CLOCK_KHZ);
  localparam int BLINK_SLOW_MS = 1000;
  localparam int BLINK_FAST_MS = 500;
  localparam int BLINK_SLOW_CYCLES = BLINK_SLOW_MS * CLK_KHZ;
  localparam int BLINK_FAST_CYCLES = BLINK_FAST_MS * CLK_KHZ;

  // Serial word
  localparam logic [4:0] SPI_WORD_BITS = 5'h10;
  localparam int READ_FLAG = 7;

  // Command addresses
  localparam logic [7:0] CMD_CONFIG = 8'h04;
  localparam logic [7:0] CMD_GLYPH = 8'h05;
  localparam logic [7:0] CMD_TEST = 8'h07;
  localparam logic [7:0] CMD_CURSOR = 8'h0f;
  localparam logic [7:0] CMD_INDICATOR_BASE = 8'h20;

  // Glyph pointer port
  localparam int POINTER_FLAG = 7;
  localparam logic [7:0] POINTER_BASE = 8'h80;
  localparam logic [7:0] POINTER_LAST = 8'haf;
  localparam logic [5:0] GLYPH_LAST = 6'h2f;
  localparam int GLYPH_ENTRIES = 48;
  localparam int GLYPH_CHARS = 24;

  // Configuration fields and reset values
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_LOCK = 1;
  localparam int CFG_RATE = 2;
  localparam int CFG_FONT = 3;
  localparam int CFG_SYNC = 4;
  localparam int CFG_CLEAR = 5;
  localparam int CFG_MODE = 6;
  localparam int CFG_PHASE = 7;
  localparam logic [6:0] CONFIG_RESET = 7'h00;
  localparam logic [7:0] CURSOR_RESET = 8'h60;
  localparam logic [7:0] INDICATOR_RESET = 8'h00;
  localparam logic [7:0] TEST_RESET = 8'h00;

  // Cursor fields
  localparam int CURSOR_BLINK = 7;
  localparam int CURSOR_ROW = 6;
  localparam int CURSOR_HIDE = 5;

  // Indicator codes
  localparam logic [1:0] IND_FIRST = 2'h1;
  localparam logic [1:0] IND_SECOND = 2'h2;
  localparam logic [1:0] IND_ON = 2'h3;

  // Byte 0 power-up glyphs, character 0 in the low bits
  localparam logic [23:0][6:0] GLYPH_DEFAULTS = {
    7'h3b, 7'h1c, 7'h4f, 7'h05, 7'h1d, 7'h76, 7'h15, 7'h0d,
    7'h47, 7'h4f, 7'h3d, 7'h4e, 7'h1f, 7'h77, 7'h7b, 7'h7f,
    7'h70, 7'h5f, 7'h5b, 7'h33, 7'h79, 7'h6d, 7'h30, 7'h7e};

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOPPING = 2'b01,
    ST_HALTED = 2'b11,
    ST_FLUSH = 2'b10
  } power_state_t;

endpackage

// file: design/spi_word_rx.sv
module spi_word_rx (
  // System
  input wire logic clk,
  input wire logic reset_n,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  // Word side
  input wire logic [7:0] reply,
  output logic word_valid,
  output logic [15:0] word
);

  logic [2:0] sclk_s;
  logic [2:0] cs_s;
  logic [1:0] din_s;
  logic [15:0] tx;
  logic [4:0] count;

  // Edges seen only past the second stage
  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire cs_fall = ~cs_s[1] & cs_s[2];
  wire cs_rise = cs_s[1] & ~cs_s[2];
  wire shift_now = ~cs_s[1] & sclk_rise;

  // Synchronisers and frame counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      din_s <= 2'h0;
      count <= 5'h00;
      word <= 16'h0000;
      word_valid <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      cs_s <= {cs_s[1:0], cs_n};
      din_s <= {din_s[0], din};
      word_valid <= cs_rise & (count == vfd_pkg::SPI_WORD_BITS);
      if (cs_fall) begin
        count <= 5'h00;
      end else if (shift_now && count != vfd_pkg::SPI_WORD_BITS) begin
        count <= count + 5'h01;
      end
      if (shift_now) begin
        word <= {word[14:0], din_s[1]}; // Extra bits keep the last 16
      end
    end
  end

  // Reply byte goes out during the next frame
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx <= 16'h0000;
    end else if (cs_fall) begin
      tx <= {8'h00, reply};
    end else if (shift_now) begin
      tx <= {tx[14:0], 1'b0};
    end
  end

  assign dout = tx[15];

endmodule

// file: design/mux_blink_timer.sv
module mux_blink_timer #(
  parameter int MUX_CYCLES = vfd_pkg::MUX_PERIOD_CYCLES,
  parameter int OSC_HALF = vfd_pkg::MUX_HALF_CYCLES,
  parameter int SLOW_CYCLES = vfd_pkg::BLINK_SLOW_CYCLES,
  parameter int FAST_CYCLES = vfd_pkg::BLINK_FAST_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic blink_clear,
  input wire logic fast,
  // Timing
  output logic period_end,
  output logic osc_out,
  output logic blink_phase
);

  logic [31:0] mux_count;
  logic [31:0] osc_count;
  logic [31:0] blink_count;

  wire [31:0] mux_last = 32'(MUX_CYCLES - 1);
  wire [31:0] osc_last = 32'(OSC_HALF - 1);
  wire [31:0] blink_last = fast ? 32'(FAST_CYCLES - 1) : 32'(SLOW_CYCLES - 1);

  // Multiplex period; halting freezes it mid-count
  always_ff @(posedge clk) begin
    if (!reset_n || restart) begin
      mux_count <= 32'h0000_0000;
      period_end <= 1'b0;
    end else begin
      period_end <= run && mux_count == mux_last;
      if (run) begin
        mux_count <= (mux_count == mux_last) ? 32'h0000_0000 : mux_count + 32'h0000_0001;
      end
    end
  end

  // Multiplex clock square wave
  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      osc_count <= 32'h0000_0000;
      osc_out <= 1'b0;
    end else if (osc_count == osc_last) begin
      osc_count <= 32'h0000_0000;
      osc_out <= ~osc_out;
    end else begin
      osc_count <= osc_count + 32'h0000_0001;
    end
  end

  // Blink halves; >= so a rate change never overshoots
  always_ff @(posedge clk) begin
    if (!reset_n || blink_clear) begin
      blink_count <= 32'h0000_0000;
      blink_phase <= 1'b0;
    end else if (run) begin
      if (blink_count >= blink_last) begin
        blink_count <= 32'h0000_0000;
        blink_phase <= ~blink_phase;
      end else begin
        blink_count <= blink_count + 32'h0000_0001;
      end
    end
  end

endmodule

// file: tb/host_serial_model.sv
module host_serial_model (
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus: clock parked low, chip deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // Command byte first, MSB first; reply bits sampled just before each rise
  task automatic xfer(input logic [15:0] word, input logic [4:0] bits,
                      output logic [15:0] reply);
    reply = 16'h0000;
    cs_n = 1'b0;
    for (int i = 15; i > 15 - int'(bits); i--) begin
      din = word[i];
      #80;
      reply[i] = dout;
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
    end
    #80;
    cs_n = 1'b1;
    // Released line shows the inverse, so no stale bit can be mistaken
    din = ~din;
    #240;
  endtask
endmodule

// file: tb/vfd_regs_properties.sv
module vfd_regs_properties #(
  parameter int MUX_PERIOD_CYCLES = vfd_pkg::MUX_PERIOD_CYCLES,
  parameter int BLINK_FAST_CYCLES = vfd_pkg::BLINK_FAST_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic reset_n,
  // Output roles
  input wire logic pump_is_clock,
  input wire logic phase_a_is_filament,
  input wire logic phase_b_is_filament,
  // Watched outputs
  input wire logic tube_driver_disable_out,
  input wire logic multiplex_clock,
  input wire logic pump_out,
  input wire logic filament_drive_out_a,
  input wire logic filament_drive_out_b,
  input wire logic blink_phase
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  int low_run;
  int run_count;
  int phase_age;

  // Run count restarts while the oscillator sits still, so a flush is timed alone
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_run <= 0;
      run_count <= 0;
      phase_age <= 0;
    end else begin
      low_run <= multiplex_clock ? 0 : low_run + 1;
      run_count <= (!tube_driver_disable_out || low_run >= 6) ? 0 : run_count + 1;
      phase_age <= $changed(blink_phase) ? 0 : phase_age + 1;
    end
  end

  pump_role_a: assert property (pump_out |-> $past(pump_is_clock))
    else $error("pump output active outside clock role");
  fil_role_a: assert property (!(filament_drive_out_a && !$past(phase_a_is_filament)) &&
      !(filament_drive_out_b && !$past(phase_b_is_filament)))
    else $error("filament output active outside filament role");
  halt_blank_a: assert property (!multiplex_clock [*6] |-> tube_driver_disable_out)
    else $error("oscillator halted while tube enabled");
  halt_quiet_a: assert property (!multiplex_clock [*6] |->
      !$past(pump_out) && !$past(filament_drive_out_a) && !$past(filament_drive_out_b))
    else $error("pump or filament driven while halted");
  fil_pair_a: assert property (!tube_driver_disable_out && phase_a_is_filament &&
      phase_b_is_filament |-> filament_drive_out_a != filament_drive_out_b)
    else $error("filament outputs not complementary");
  osc_half_a: assert property ($rose(multiplex_clock) |=>
      multiplex_clock ##1 !multiplex_clock)
    else $error("oscillator half period wrong");
  osc_run_a: assert property (!tube_driver_disable_out |-> ##[0:3] $changed(multiplex_clock))
    else $error("oscillator stalled while displaying");
  flush_hold_a: assert property ($fell(tube_driver_disable_out) |->
      run_count >= MUX_PERIOD_CYCLES - 6)
    else $error("tube enabled before a whole flush period");
  blink_rate_a: assert property ($changed(blink_phase) |->
      phase_age >= BLINK_FAST_CYCLES - 1)
    else $error("blink phase toggled too early");

  cover property ($fell(tube_driver_disable_out));
  cover property ($rose(blink_phase));
  cover property (!multiplex_clock [*6]);
endmodule

bind vfd_shutdown_cursor_font_regs vfd_regs_properties #(
  .MUX_PERIOD_CYCLES(MUX_PERIOD_CYCLES), .BLINK_FAST_CYCLES(BLINK_FAST_CYCLES)
) props_inst (
  .clk(clk), .reset_n(reset_n), .pump_is_clock(pump_is_clock),
  .phase_a_is_filament(phase_a_is_filament), .phase_b_is_filament(phase_b_is_filament),
  .tube_driver_disable_out(tube_driver_disable_out), .multiplex_clock(multiplex_clock),
  .pump_out(pump_out), .filament_drive_out_a(filament_drive_out_a),
  .filament_drive_out_b(filament_drive_out_b), .blink_phase(blink_phase)
);

// file: tb/test_vfd_shutdown_cursor_font_regs.sv
module test_vfd_shutdown_cursor_font_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, sclk, cs_n, din, dout, digit_wide, disable_out, mux_clk, pump;
  logic pump_role, fil_a_role, fil_b_role, fil_a, fil_b, phase, mode, font, locked;
  logic row, lit;
  logic [4:0] glyph_char;
  logic [13:0] segs;
  logic [5:0] digit;
  logic [3:0] ind_1, ind_2, ind_3, ind_4;
  logic [15:0] reply;
  int miscompares = 0;
  int tests_run = 0;
  // Indicator byte writes and the lit nibble {4th,3rd,2nd,1st} per blink half
  typedef struct packed {
    logic [15:0] word;
    logic [3:0] first_half;
    logic [3:0] second_half;
  } ind_row_t;
  ind_row_t rows [4] = '{'{16'h20e4, 4'ha, 4'hc}, '{16'h211b, 4'h5, 4'h3},
                         '{16'h2200, 4'h0, 4'h0}, '{16'h23ff, 4'hf, 4'hf}};

  // Short counts keep the run brief
  vfd_shutdown_cursor_font_regs #(.MUX_PERIOD_CYCLES(20), .MUX_HALF_CYCLES(2),
    .BLINK_SLOW_CYCLES(64), .BLINK_FAST_CYCLES(32)) vfd_shutdown_cursor_font_regs_inst (
    .clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .pump_is_clock(pump_role), .phase_a_is_filament(fil_a_role),
    .phase_b_is_filament(fil_b_role), .glyph_char(glyph_char), .digit_wide(digit_wide),
    .glyph_segments(segs), .tube_driver_disable_out(disable_out), .multiplex_clock(mux_clk),
    .pump_out(pump), .filament_drive_out_a(fil_a), .filament_drive_out_b(fil_b),
    .blink_phase(phase), .display_mode(mode), .font_select(font), .config_locked(locked),
    .cursor_row(row), .cursor_digit(digit), .cursor_lit(lit), .indicator_first(ind_1),
    .indicator_second(ind_2), .indicator_third(ind_3), .indicator_fourth(ind_4));
  host_serial_model host_serial_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Whole word, then room for the register update to land
  task automatic send(input logic [15:0] w);
    host_serial_model_inst.xfer(w, 5'd16, reply);
    repeat (8) @(negedge clk);
  endtask

  task automatic glyph(input logic [4:0] c, input logic w, input logic [15:0] exp);
    @(negedge clk);
    glyph_char = c;
    digit_wide = w;
    repeat (2) @(negedge clk);
    check(16'(segs), exp);
  endtask

  // Fresh entry into the half, so the check sits far from the next toggle
  task automatic wait_phase(input logic v);
    for (int i = 0; i < 200 && phase === v; i++) @(negedge clk);
    for (int i = 0; i < 200 && phase !== v; i++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask

  // Cycles between two blink toggles after a config write
  task automatic blink_period(input logic [15:0] cfg, input int exp);
    logic p;
    int n;
    send(cfg);
    p = phase;
    for (int i = 0; i < 200 && phase === p; i++) @(negedge clk);
    p = phase;
    n = 0;
    for (int i = 0; i < 200 && phase === p; i++) begin
      @(negedge clk);
      n++;
    end
    check(16'(n), 16'(exp));
    check(16'(disable_out), 16'h0000);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #1_500_000;
    miscompares++;
    end_of_test();
  end

  initial begin
    reset_n = 1'b0;
    {pump_role, fil_a_role, fil_b_role, digit_wide} = 4'hf;
    glyph_char = 5'h00;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    check(16'({disable_out, row, digit}), 16'h00e0);
    // Glyph loading while shut down
    send(16'h0580);
    send(16'h0555);
    send(16'h052a);
    glyph(5'd0, 1'b1, 16'h1555);
    glyph(5'd0, 1'b0, 16'h0055);
    glyph(5'd1, 1'b0, 16'h0030);
    send(16'h05b0);
    send(16'h0511);
    glyph(5'd0, 1'b1, 16'h1511);
    send(16'h0580);
    send(16'h8500);
    send(16'h8500);
    check(reply, 16'h0011);
    send(16'h0000);
    check(reply, 16'h002a);
    send(16'h05af);
    send(16'h0501);
    send(16'h0502);
    glyph(5'd23, 1'b1, 16'h00bb);
    blink_period(16'h0401, 64);
    send(16'h0f05);
    check(16'({row, digit, lit}), 16'h000b);
    foreach (rows[i]) send(rows[i].word);
    send(16'h0fc5);
    for (int h = 0; h < 2; h++) begin
      wait_phase(h[0]);
      check(16'({row, digit, lit}), (h == 0) ? 16'h008b : 16'h008a);
      foreach (rows[i]) check(16'({ind_4[i], ind_3[i], ind_2[i], ind_1[i]}),
                              16'((h == 0) ? rows[i].first_half : rows[i].second_half));
    end
    send(16'h0f60);
    check(16'({row, digit, lit}), 16'h00c0);
    // Short frame must not reach the shutdown bit
    host_serial_model_inst.xfer(16'h0400, 5'd15, reply);
    repeat (40) @(negedge clk);
    check(16'(disable_out), 16'h0000);
    send(16'h0701);
    send(16'h0404);
    repeat (40) @(negedge clk);
    check(16'(disable_out), 16'h0000);
    send(16'h0700);
    repeat (40) @(negedge clk);
    check(16'({disable_out, pump, fil_a, fil_b}), 16'h0008);
    send(16'h044a);
    send(16'h2203);
    send(16'h8400);
    send(16'h0000);
    check(16'(reply[7:0]), 16'({phase, 7'h4a}));
    check(16'({mode, font, locked, ind_1[2]}), 16'h000f);
    check(16'({ind_4[3], ind_3[3], ind_2[3], ind_1[3]}), 16'h000f);
    blink_period(16'h0405, 32);
    // Pump and filament A roles withdrawn while running: both must go quiet
    {pump_role, fil_a_role} = 2'b00;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      if (i > 1) check(16'({pump, fil_a}), 16'h0000);
    end
    {pump_role, fil_a_role} = 2'b11;
    repeat (4) @(negedge clk);
    check(16'(fil_a ^ fil_b), 16'h0001);
    send(16'h0425);
    check(16'({ind_4, ind_3, ind_2, ind_1}), 16'h0000);
    end_of_test();
  end
endmodule
